// File: src/lmt_target.sv
// LPC memory cycle target: decodes single-byte reads and writes.
// Assumes one clock, bus levels synchronous, resolved nibble on lad_i.
`timescale 1ns/1ps
`default_nettype none
`include "lmt_defines.svh"
// Functional notes
// - Start field is last nibble with frame low
// - Start nibble 0000 marks memory cycle
// - Kind nibble: bits 3:2 01, bit1 write
// - Eight address nibbles, most significant first
// - Host drives ones clock 11 on read, then releases
// - Device drives from clock 13 read, 15 write
// - Read sync 0000 in clock 13
// - Read data low nibble 14, high 15
// - Write data low nibble 11, high 12
// - Host drives ones clock 13 on write
// - Write sync 0000 in clock 15
// - Device ones clock 16, host back 17 (on reads the target floats from clock 16, no ones)
// - Nibbles sampled on rising clock edge
// - Frame low mid-cycle terminates the cycle
// - Abort nibble returns interface to idle
// - Abort keeps command sequence progress intact
// - Host may repeat aborted cycle later
// - Address bit 22 selects array or registers
// - Identity bits must match strapped pins
// - Busy device completes cycles, skips writes
module lmt_target (
  input wire logic clk, // Bus clock
  input wire logic rstn, // Synchronous reset, active low
  lmt_bus_if.dev bus, // Frame and nibble bus
  input wire logic [3:0] strapped_identity_pins, // Device identity
  input wire logic busy, // Internal program or erase running
  input wire logic [7:0] rd_data, // Byte returned on reads
  output logic [31:0] acc_addr, // Address of last access
  output logic acc_array, // Access targets flash array
  output logic rd_stb, // Read fetch pulse
  output logic wr_stb, // Write pulse
  output logic [7:0] wr_data // Byte of last write, or read byte after a read
);
  lmt_pkg::lmt_state_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;
  logic wr_reg, wr_next;
  logic [31:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;
  logic rd_stb_reg, rd_stb_next, wr_stb_reg, wr_stb_next;
  logic [3:0] lad_reg, lad_next;
  logic drv_reg, drv_next;

  // Identity bits carried in the address
  function automatic logic id_match(input logic [31:0] a,
                                    input logic [3:0] id);
    id_match = (a[`LMT_ID3_POS] == id[3]) &&
      (a[`LMT_ID20_HI:`LMT_ID20_LO] == id[2:0]);
  endfunction : id_match

  // Cycle timing, one nibble per clock, taken at the closing edge:
  //   clock 1 start, clock 2 kind and direction
  //   clocks 3 to 10 address, most significant nibble first
  //   read: 11 host ones, 12 float, 13 sync, 14 and 15 data
  //   write: 11 and 12 data, 13 host ones, 14 float
  //   write: 15 sync, 16 ones, then the host takes the bus back
  // Drive is planned one clock ahead in lad_next and drv_next,
  // so the target nibble is a flip-flop and never glitches; only the enable passes the frame gate.
  // A low frame overrides every state: that is both the start
  // detector and the abort path, and it leaves no partial cycle.
  // Write pulses are suppressed while busy, but the handshake
  // still completes so the host never stalls on a busy part.
  // Next state of the cycle decoder
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    rd_stb_next = 1'b0;
    wr_stb_next = 1'b0;
    lad_next = `LMT_TAR_NIB;
    drv_next = 1'b0;
    if (!bus.frame_n) begin
      // Abort nibble or any other: only this bus cycle ends
      st_next = (bus.lad_i == `LMT_START_MEM) ? lmt_pkg::ST_KIND :
        lmt_pkg::ST_IDLE;
    end else begin
      case (st_reg)
        // Waiting for a start nibble under a low frame
        lmt_pkg::ST_IDLE: st_next = lmt_pkg::ST_IDLE;
        // Kind and direction nibble
        lmt_pkg::ST_KIND: begin
          wr_next = bus.lad_i[`LMT_DIR_POS];
          cnt_next = 3'h0;
          st_next = (bus.lad_i[`LMT_KIND_POS -: 2] == `LMT_KIND_MEM) ?
            lmt_pkg::ST_ADDR : lmt_pkg::ST_IDLE;
        end
        // Address shift, identity checked on the last nibble
        lmt_pkg::ST_ADDR: begin
          addr_next = {addr_reg[27:0], bus.lad_i};
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == `LMT_ADDR_NIBS) begin
            cnt_next = 3'h0;
            if (!id_match({addr_reg[27:0], bus.lad_i},
                strapped_identity_pins))
              st_next = lmt_pkg::ST_SKIP;
            else if (wr_reg)
              st_next = lmt_pkg::ST_WDAT;
            else begin
              st_next = lmt_pkg::ST_TAR0;
              rd_stb_next = 1'b1;
            end
          end
        end
        // Write data, low nibble first
        lmt_pkg::ST_WDAT: begin
          cnt_next = cnt_reg + 3'h1;
          if (cnt_reg == 3'h0)
            data_next[3:0] = bus.lad_i;
          else begin
            data_next[7:4] = bus.lad_i;
            st_next = lmt_pkg::ST_TAR0;
          end
        end
        // Host ones clock, bus still the host's
        lmt_pkg::ST_TAR0: st_next = lmt_pkg::ST_TAR1;
        // Float clock, target arms its drive
        lmt_pkg::ST_TAR1: begin
          st_next = lmt_pkg::ST_SYNC;
          drv_next = 1'b1;
          lad_next = `LMT_SYNC_READY;
        end
        // Sync on the bus, plan data or closing ones
        lmt_pkg::ST_SYNC: begin
          cnt_next = 3'h0;
          drv_next = 1'b1;
          if (wr_reg) begin
            st_next = lmt_pkg::ST_DTAR;
            lad_next = `LMT_TAR_NIB;
            wr_stb_next = !busy;
          end else begin
            st_next = lmt_pkg::ST_RDAT;
            lad_next = data_reg[3:0];
          end
        end
        // Low nibble on the bus, plan the high one
        lmt_pkg::ST_RDAT: begin
          st_next = lmt_pkg::ST_IDLE;
          drv_next = 1'b1;
          lad_next = data_reg[7:4];
        end
        // Closing ones on the bus, released after this clock
        lmt_pkg::ST_DTAR: st_next = lmt_pkg::ST_IDLE;
        // Other device's cycle: silent until the next frame
        lmt_pkg::ST_SKIP: st_next = lmt_pkg::ST_SKIP;
        // Illegal code: recover to idle
        default: st_next = lmt_pkg::ST_IDLE;
      endcase
    end
  end

  // The fetch pulse stands in clock 11; the byte source has
  // that clock to answer, and the byte is taken at its end.
  // The byte moves to the data register in the float clock,
  // in time to be driven as the low nibble of clock 14.
  // Read byte captured at the edge that ends the fetch pulse
  logic [7:0] rdat_reg;
  always_ff @(posedge clk) begin
    if (!rstn) rdat_reg <= 8'h00;
    else if (rd_stb_reg) rdat_reg <= rd_data;
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_reg <= lmt_pkg::ST_IDLE;
      cnt_reg <= 3'h0;
      wr_reg <= 1'b0;
      addr_reg <= 32'h0000_0000;
      data_reg <= 8'h00;
      rd_stb_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      lad_reg <= 4'hf;
      drv_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      data_reg <= (st_reg == lmt_pkg::ST_TAR1 && !wr_reg) ? rdat_reg :
        data_next;
      rd_stb_reg <= rd_stb_next;
      wr_stb_reg <= wr_stb_next;
      lad_reg <= lad_next;
      drv_reg <= drv_next;
    end
  end

  // The frame gate is the only combinational path to the bus
  // enable, so a host abort never meets a driving target.
  // Access outputs hold the last decoded cycle until the next
  // address phase overwrites them.
  // Bus drive, released at once when the frame drops
  assign bus.dev_lad_o = lad_reg;
  assign bus.dev_lad_oe_n = !(drv_reg && bus.frame_n);
  assign acc_addr = addr_reg;
  assign acc_array = addr_reg[`LMT_A22_POS];
  assign rd_stb = rd_stb_reg;
  assign wr_stb = wr_stb_reg;
  assign wr_data = data_reg;
endmodule : lmt_target
`default_nettype wire

// File: src/lmt_defines.svh
// Constants for the LPC memory cycle target and its host controller.
// Assumes inclusion by bare name from design files.
`ifndef LMT_DEFINES_SVH
`define LMT_DEFINES_SVH
`define LMT_START_MEM 4'h0
`define LMT_ABORT_NIB 4'hf
`define LMT_TAR_NIB 4'hf
`define LMT_SYNC_READY 4'h0
`define LMT_KIND_MEM 2'h1
`define LMT_KIND_POS 3
`define LMT_DIR_POS 1
`define LMT_A22_POS 22
`define LMT_ID3_POS 23
`define LMT_ID20_HI 21
`define LMT_ID20_LO 19
`define LMT_ADDR_NIBS 3'h7
`endif

// File: src/lmt_pkg.sv
// Types used by the target end of the LPC memory cycle link.
// Assumes the defines header is compiled alongside.
package lmt_pkg;
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_KIND = 10'h002,
    ST_ADDR = 10'h004,
    ST_WDAT = 10'h008,
    ST_TAR0 = 10'h010,
    ST_TAR1 = 10'h020,
    ST_SYNC = 10'h040,
    ST_RDAT = 10'h080,
    ST_DTAR = 10'h100,
    ST_SKIP = 10'h200
  } lmt_state_t;
endpackage : lmt_pkg

// File: src/lmt_bus_if.sv
// Interface carrying the LPC frame strobe and the shared nibble bus.
// Assumes the bench resolves the nibble wire from the output enables.
`timescale 1ns/1ps
`default_nettype none
interface lmt_bus_if;
  logic frame_n;
  logic [3:0] host_lad_o;
  logic host_lad_oe_n;
  logic [3:0] dev_lad_o;
  logic dev_lad_oe_n;
  logic [3:0] lad_i;
  modport host (output frame_n, output host_lad_o, output host_lad_oe_n,
    input lad_i);
  modport dev (input frame_n, output dev_lad_o, output dev_lad_oe_n,
    input lad_i);
endinterface : lmt_bus_if
`default_nettype wire

// File: src/lmt_host.sv
// Host end: issues LPC memory reads, writes and aborts.
// Assumes one clock shared with the target.
`timescale 1ns/1ps
`default_nettype none
`include "lmt_defines.svh"
module lmt_host (
  input wire logic clk, // Bus clock
  input wire logic rstn, // Synchronous reset, active low
  lmt_bus_if.host bus, // Frame and nibble bus
  input wire logic req, // Start a cycle when idle
  input wire logic req_wr, // Cycle is a write
  input wire logic [31:0] req_addr, // Cycle address
  input wire logic [7:0] req_data, // Write byte
  input wire logic abort, // Abort current cycle
  output logic busy, // Cycle in progress
  output logic done, // Cycle end pulse
  output logic [7:0] rd_byte // Byte from last read, or write byte after a write
);
  logic [4:0] clk_reg, clk_next;
  logic act_reg, act_next, wr_reg, wr_next, done_reg, done_next;
  logic [31:0] a_reg, a_next;
  logic [7:0] d_reg, d_next;
  logic [3:0] o_reg, o_next;
  logic oen_reg, oen_next, fr_reg, fr_next;

  // Sequencer over the seventeen clocks of a cycle
  always_comb begin
    clk_next = clk_reg;
    act_next = act_reg;
    wr_next = wr_reg;
    a_next = a_reg;
    d_next = d_reg;
    done_next = 1'b0;
    o_next = `LMT_TAR_NIB;
    oen_next = 1'b1;
    fr_next = 1'b1;
    if (abort && act_reg) begin
      act_next = 1'b0;
      fr_next = 1'b0;
      oen_next = 1'b0;
      o_next = `LMT_ABORT_NIB;
    end else if (!act_reg) begin
      if (req) begin
        act_next = 1'b1;
        wr_next = req_wr;
        a_next = req_addr;
        d_next = req_data;
        clk_next = 5'd1;
        fr_next = 1'b0;
        oen_next = 1'b0;
        o_next = `LMT_START_MEM;
      end
    end else begin
      clk_next = clk_reg + 5'd1;
      if (clk_next == 5'd2) begin
        oen_next = 1'b0;
        o_next = {`LMT_KIND_MEM, wr_reg, 1'b0};
      end else if (clk_next <= 5'd10) begin
        oen_next = 1'b0;
        o_next = a_reg[31:28];
        a_next = {a_reg[27:0], 4'h0};
      end else if (wr_reg && clk_next == 5'd11) begin
        oen_next = 1'b0;
        o_next = d_reg[3:0];
      end else if (wr_reg && clk_next == 5'd12) begin
        oen_next = 1'b0;
        o_next = d_reg[7:4];
      end else if (clk_next == (wr_reg ? 5'd13 : 5'd11)) begin
        oen_next = 1'b0;
      end
      if (!wr_reg && clk_reg == 5'd14) d_next[3:0] = bus.lad_i;
      if (!wr_reg && clk_reg == 5'd15) d_next[7:4] = bus.lad_i;
      if (clk_reg == 5'd17) begin
        act_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      clk_reg <= 5'd0;
      act_reg <= 1'b0;
      wr_reg <= 1'b0;
      a_reg <= 32'h0000_0000;
      d_reg <= 8'h00;
      done_reg <= 1'b0;
      o_reg <= 4'hf;
      oen_reg <= 1'b1;
      fr_reg <= 1'b1;
    end else begin
      clk_reg <= clk_next;
      act_reg <= act_next;
      wr_reg <= wr_next;
      a_reg <= a_next;
      d_reg <= d_next;
      done_reg <= done_next;
      o_reg <= o_next;
      oen_reg <= oen_next;
      fr_reg <= fr_next;
    end
  end

  assign bus.frame_n = fr_reg;
  assign bus.host_lad_o = o_reg;
  assign bus.host_lad_oe_n = oen_reg;
  assign busy = act_reg;
  assign done = done_reg;
  assign rd_byte = d_reg;
endmodule : lmt_host
`default_nettype wire

// File: bench/lmt_asserts.sv
// Checker for the nibble link between the host and target ends.
// Assumes it sits beside the bus interface, on one clock.
`timescale 1ns/1ps
`default_nettype none
module lmt_asserts (
  input wire logic clk, // Bus clock
  input wire logic rstn, // Sync reset, active low
  input wire logic frame_n, // Frame strobe
  input wire logic [3:0] host_lad_o, // Host nibble
  input wire logic host_lad_oe_n, // Host enable, low drives
  input wire logic [3:0] dev_lad_o, // Target nibble
  input wire logic dev_lad_oe_n, // Target enable, low drives
  input wire logic [3:0] lad_i, // Resolved nibble
  input wire logic [3:0] strapped_identity_pins // Target identity
);
  logic [4:0] n_next, n_reg;
  logic [3:0] knd_next, knd_reg;
  logic [31:0] adr_next, adr_reg;
  logic idbad, ok, rd, wr;
  // Clock number of the nibble sampled at this edge
  always_comb begin
    n_next = 5'h0;
    knd_next = knd_reg;
    adr_next = adr_reg;
    if (!frame_n) n_next = (lad_i == 4'h0) ? 5'h1 : 5'h0;
    else if (n_reg != 5'h0 && n_reg < 5'h11) n_next = n_reg + 5'h1;
    if (n_next == 5'h2) knd_next = lad_i;
    if (n_next > 5'h2 && n_next < 5'hb) adr_next = {adr_reg[27:0], lad_i};
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      n_reg <= 5'h0;
      knd_reg <= 4'hf;
      adr_reg <= 32'h0;
    end else begin
      n_reg <= n_next;
      knd_reg <= knd_next;
      adr_reg <= adr_next;
    end
  end
  // Cycle qualifiers from kind and identity
  assign idbad = adr_reg[23] != strapped_identity_pins[3]
    || adr_reg[21:19] != strapped_identity_pins[2:0];
  assign ok = knd_reg[3:2] == 2'h1 && !idbad;
  assign rd = ok && !knd_reg[1];
  assign wr = ok && knd_reg[1];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_ack;
    (!dev_lad_oe_n && dev_lad_o == 4'h0) ##1
    (!dev_lad_oe_n && dev_lad_o == 4'hf) ##1 dev_lad_oe_n;
  endsequence
  sequence s_tar0;
    host_lad_o == 4'hf && !host_lad_oe_n;
  endsequence
  property p_rd_sync;
    rd && n_next == 5'hd |-> !dev_lad_oe_n && dev_lad_o == 4'h0;
  endproperty
  a_rd_sync: assert property (p_rd_sync) else $error("read sync bad");
  property p_rd_drive;
    rd && n_next == 5'he |-> !dev_lad_oe_n ##1 !dev_lad_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("read data");
  property p_wr_ack;
    wr && n_next == 5'hf |-> s_ack;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write ack bad");
  property p_wr_host;
    wr && n_next == 5'hd |-> s_tar0 ##1 host_lad_oe_n[*3];
  endproperty
  a_wr_host: assert property (p_wr_host) else $error("write tar");
  property p_rd_host;
    rd && n_next == 5'hb |-> s_tar0 ##1 host_lad_oe_n[*4];
  endproperty
  a_rd_host: assert property (p_rd_host) else $error("read tar");
  property p_frame_rel;
    !frame_n |-> dev_lad_oe_n;
  endproperty
  a_frame_rel: assert property (p_frame_rel) else $error("no release");
  property p_abort;
    !frame_n && lad_i == 4'hf |-> dev_lad_oe_n[*8];
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");
  property p_id_skip;
    n_next == 5'hb && knd_reg[3:2] == 2'h1 && idbad |-> ##1 dev_lad_oe_n[*6];
  endproperty
  a_id_skip: assert property (p_id_skip) else $error("id not skipped");
endmodule : lmt_asserts
`default_nettype wire

// File: bench/test_lpc_memory_cycle_target.sv
// Testbench joining host and target ends over the nibble bus.
// Assumes the design sources and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_lpc_memory_cycle_target;
  logic clk, rstn, req, req_wr, abort, tbusy, hbusy, done, acc_array;
  logic rd_stb, wr_stb;
  logic [31:0] req_addr, acc_addr;
  logic [7:0] req_data, rd_data, wr_data, rd_byte;
  logic [3:0] id;
  int err_total, samples_checked, nwr, nrd;
  lmt_bus_if bus();
  // Pull-up resolution of the shared nibble
  assign bus.lad_i = !bus.host_lad_oe_n ? bus.host_lad_o :
    !bus.dev_lad_oe_n ? bus.dev_lad_o : 4'hf;
  lmt_target u_lmt_target (.clk(clk), .rstn(rstn), .bus(bus),
    .strapped_identity_pins(id), .busy(tbusy), .rd_data(rd_data),
    .acc_addr(acc_addr), .acc_array(acc_array), .rd_stb(rd_stb),
    .wr_stb(wr_stb), .wr_data(wr_data));
  lmt_host u_lmt_host (.clk(clk), .rstn(rstn), .bus(bus), .req(req),
    .req_wr(req_wr), .req_addr(req_addr), .req_data(req_data),
    .abort(abort), .busy(hbusy), .done(done), .rd_byte(rd_byte));
  lmt_asserts u_lmt_asserts (.clk(clk), .rstn(rstn),
    .frame_n(bus.frame_n), .host_lad_o(bus.host_lad_o),
    .host_lad_oe_n(bus.host_lad_oe_n), .dev_lad_o(bus.dev_lad_o),
    .dev_lad_oe_n(bus.dev_lad_oe_n), .lad_i(bus.lad_i),
    .strapped_identity_pins(id));
  function automatic logic [7:0] val(input logic [31:0] a);
    val = a[7:0] ^ a[26:19];
  endfunction : val
  function automatic logic [31:0] mk(input logic [3:0] i, input logic [31:0] r);
    mk = {8'hff, i[3], r[22], i[2:0], r[18:0]};
  endfunction : mk
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // One host cycle, optionally aborted after ab clocks
  task automatic run(input logic w, input logic [31:0] a, input logic [7:0] d,
    input int ab);
    int n;
    n = 0;
    req <= 1'b1;
    req_wr <= w;
    req_addr <= a;
    req_data <= d;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    while ((ab > 0 ? hbusy !== 1'b0 : done !== 1'b1) && n < 40) begin
      @(posedge clk);
      n++;
      abort <= (n == ab);
    end
    if (n == 40) chk("finish", 32'h0, 32'h1);
    @(posedge clk);
  endtask : run
  // Clock source
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Memory model: byte stands before the target's capture edge
  assign rd_data = val(acc_addr);
  // Strobe counters
  always @(posedge clk) begin
    if (wr_stb === 1'b1) nwr++;
    if (rd_stb === 1'b1) nrd++;
  end
  // Hang guard
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  // Main sequence
  initial begin
    logic [31:0] a;
    logic [7:0] d;
    logic [3:0] idv;
    logic w, bz;
    int k0;
    {rstn, req, req_wr, abort, tbusy} = 5'h0;
    {req_addr, req_data, id} = 44'h0;
    k0 = $urandom(51840);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      idv = $urandom;
      w = $urandom;
      bz = $urandom;
      d = $urandom;
      a = mk(idv, i == 0 ? 32'h0 : (i == 1 ? 32'hffffffff : $urandom));
      id <= idv;
      tbusy <= bz;
      k0 = nwr;
      run(w, a, d, 0);
      chk("acc_addr", a, acc_addr);
      chk("acc_array", {31'h0, a[22]}, {31'h0, acc_array});
      if (!w) chk("rd_byte", {24'h0, val(a)}, {24'h0, rd_byte});
      else chk("wr_count", k0 + !bz, nwr);
      if (w && !bz) chk("wr_data", {24'h0, d}, {24'h0, wr_data});
    end
    tbusy <= 1'b0;
    k0 = nwr;
    a = mk(idv, $urandom);
    run(1'b1, a, 8'h3c, 6);
    chk("host_idle", 32'h0, {31'h0, hbusy});
    chk("wr_abort", k0, nwr);
    run(1'b1, a, 8'hc3, 0);
    chk("wr_retry", k0 + 1, nwr);
    chk("wr_data", 32'hc3, {24'h0, wr_data});
    k0 = nrd;
    a[23] = !a[23];
    run(1'b0, a, 8'h0, 20);
    chk("rd_skip", k0, nrd);
    print_verdict();
  end
endmodule : test_lpc_memory_cycle_target
`default_nettype wire
